// [hw/smbsg_top.sv]
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none
module smbsg_top
	import smbsg_pkg::*;
(
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic [31:0]            o_prdata,
	// primary bus and system inputs
	input  wire logic              i_upstream_bus_clock,
	input  wire logic              i_upstream_bus_data,
	output logic                   o_upstream_bus_data,
	output logic                   o_upstream_bus_data_oe,
	input  wire logic              i_host_power_good,
	input  wire logic              i_clk_32k,
	// general pins
	input  wire logic [GPIO_N-1:0] i_gpio,
	output logic [GPIO_N-1:0]      o_gpio,
	output logic [GPIO_N-1:0]      o_gpio_oe
);

	// whole state of the block
	typedef struct packed {
		logic [SYNC_N-1:0] s1;      // first sync stage
		logic [SYNC_N-1:0] s2;      // second sync stage
		logic [SYNC_N-1:0] s3;      // third sync stage
		logic [SYNC_N-1:0] stb;     // agreed input levels
		logic [GPIO_N-1:0] dir;     // 1 = output
		logic [GPIO_N-1:0] dout;    // output values
		logic [7:0]        func;    // alternate functions
		logic [LO_N-1:0]   alfen;   // flash enables
		logic [LO_N-1:0]   iden;    // address input enables
		logic [15:0]       drv;     // drive style per low pin
		logic [7:0]        erise;   // 1 = rising edge
		logic [7:0]        irqen;   // event enables
		logic [7:0]        route;   // 1 = alert, 0 = event
		logic [7:0]        stat;    // sticky events
		logic [15:0]       ldiv;    // flash period in ticks
		logic [15:0]       lcnt;    // flash phase
		logic [LO_N-1:0]   duty50;  // 1 = half duty
		logic [LO_N-1:0]   led;     // flash levels
		logic [LO_N-1:0]   id;      // cascade address
		logic [SCR_N-1:0][7:0] scr; // scratchpad
		smbsg_own_t        own;     // data line owner
		logic [3:0]        hold;    // release hold-off
		logic [GPIO_N-1:0] pout;    // pin values
		logic [GPIO_N-1:0] poe;     // pin enables
		logic              up_oe;   // primary data pull
		logic              pready;  // apb ready
		logic              pslverr; // apb error
		logic [31:0]       prdata;  // apb read data
	} smbsg_state_t;

	smbsg_state_t st_r;   // registered state
	smbsg_state_t st_nxt; // next state

	// scratch address check
	function automatic logic is_scr(input logic [ADDR_W-1:0] a);
		is_scr = (a >= OFS_SCR) && (a < OFS_SCR + 8'(4 * SCR_N)) && (a[1:0] == 2'h0);
	endfunction

	// scratch byte index
	function automatic logic [3:0] scr_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFS_SCR;
		scr_idx = d[5:2];
	endfunction

	// mapped address check
	function automatic logic is_map(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_DIR, OFS_OUT, OFS_IN, OFS_FUNC, OFS_ALT, OFS_DRV,
			OFS_EVC, OFS_STAT, OFS_LED, OFS_STS: is_map = 1'b1;
			default: is_map = is_scr(a);
		endcase
	endfunction

	// locals of the next-state process
	logic              wr;      // write strobe
	logic              setup;   // setup phase
	logic [7:0]        clr;     // status clear mask
	logic [7:0]        hit;     // edges this cycle
	logic              pg;      // host power good
	logic              tick;    // 32 kHz rising edge
	logic [15:0]       thr;     // flash threshold
	logic [1:0]        sel;     // segment choice
	logic              conn;    // a segment is joined
	logic              upd;     // primary data level
	logic              dnd;     // segment data level
	logic [4:0]        dpin;    // segment data pin
	logic [4:0]        cpin;    // segment clock pin
	logic [31:0]       rd;      // read value
	logic              lvl;     // pin value scratch
	int                p;       // pin index

	// next state
	always_comb begin
		st_nxt = st_r;
		wr = i_psel & i_penable & st_r.pready & i_pwrite;
		setup = i_psel & ~i_penable;
		clr = 8'h00;
		hit = 8'h00;
		rd = 32'h0000_0000;
		lvl = 1'b0;
		p = 0;
		// three stage sync, change once stages agree
		st_nxt.s1 = {i_clk_32k, i_host_power_good, i_upstream_bus_data,
			i_upstream_bus_clock, i_gpio};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int b = 0; b < SYNC_N; b++) begin
			if (st_r.s2[b] == st_r.s3[b]) begin
				st_nxt.stb[b] = st_r.s3[b];
			end
		end
		pg = st_r.stb[SY_HOST_POWER_GOOD];
		// register writes
		if (wr) begin
			unique case (i_paddr)
				OFS_DIR: st_nxt.dir = i_pwdata[GPIO_N-1:0];
				OFS_OUT: st_nxt.dout = i_pwdata[GPIO_N-1:0];
				OFS_FUNC: st_nxt.func = i_pwdata[7:0];
				OFS_ALT: begin
					st_nxt.alfen = i_pwdata[7:0];
					st_nxt.iden = i_pwdata[15:8];
				end
				OFS_DRV: st_nxt.drv = i_pwdata[15:0];
				OFS_EVC: begin
					st_nxt.erise = i_pwdata[7:0];
					st_nxt.irqen = i_pwdata[15:8];
					st_nxt.route = i_pwdata[23:16];
				end
				// ones clear sticky status bits
				OFS_STAT: clr = i_pwdata[7:0];
				// flash period and duty choice
				OFS_LED: begin
					st_nxt.ldiv = i_pwdata[15:0];
					st_nxt.duty50 = i_pwdata[23:16];
				end
				default: begin
					if (is_scr(i_paddr)) begin
						st_nxt.scr[scr_idx(i_paddr)] = i_pwdata[7:0];
					end
				end
			endcase
		end
		// edge events on pins 8..15, set wins over clear
		for (int k = 0; k < 8; k++) begin
			p = EV_LO + k;
			if (st_nxt.stb[p] != st_r.stb[p] && !st_r.dir[p] && st_r.irqen[k]) begin
				hit[k] = (st_nxt.stb[p] == st_r.erise[k]);
			end
		end
		st_nxt.stat = (st_r.stat & ~clr) | hit;
		// flash timing on 32 kHz edges
		tick = st_nxt.stb[SY_CLK32] & ~st_r.stb[SY_CLK32];
		// phase wraps at the programmed period
		if (tick) begin
			if (st_r.lcnt + 16'h0001 >= st_r.ldiv) begin
				st_nxt.lcnt = 16'h0000;
			end else begin
				st_nxt.lcnt = st_r.lcnt + 16'h0001;
			end
		end
		for (int k = 0; k < LO_N; k++) begin
			thr = st_r.duty50[k] ? st_r.ldiv / 16'(DUTY50_DIV) : st_r.ldiv / 16'(DUTY10_DIV);
			st_nxt.led[k] = st_r.lcnt < thr;
			// address pins sampled while enabled as inputs
			if (st_r.iden[k] && !st_r.dir[k]) begin
				st_nxt.id[k] = st_r.stb[k];
			end
		end
		// segment choice
		sel = st_r.func[FB_SELPIN] ? {st_r.stb[P_SEL1], st_r.stb[P_SEL0]}
			: st_r.func[FB_SELSW +: 2];
		dpin = 5'(P_S1DAT);
		cpin = 5'(P_S1CLK);
		conn = 1'b0;
		unique case (sel)
			SEL_SEG1: conn = st_r.func[FB_SEG1];
			SEL_SEG2: begin
				conn = st_r.func[FB_SEG2];
				dpin = 5'(P_S2DAT);
				cpin = 5'(P_S2CLK);
			end
			SEL_SEG3: begin
				conn = st_r.func[FB_SEG3];
				dpin = 5'(P_S3DAT);
				cpin = 5'(P_S3CLK);
			end
			SEL_NONE: conn = 1'b0;
		endcase
		conn = conn & pg;
		upd = st_r.stb[SY_UPDAT];
		dnd = st_r.stb[dpin];
		// data line ownership, first side low leads
		unique case (st_r.own)
			OWN_IDLE: begin
				if (conn && !upd) begin
					st_nxt.own = OWN_UP;
				end else if (conn && !dnd) begin
					st_nxt.own = OWN_DN;
				end
			end
			// primary leads until it lets go
			OWN_UP: begin
				if (upd || !conn) begin
					st_nxt.own = OWN_HOLD;
					st_nxt.hold = HOLD_CYC;
				end
			end
			// segment leads until it lets go
			OWN_DN: begin
				if (dnd || !conn) begin
					st_nxt.own = OWN_HOLD;
					st_nxt.hold = HOLD_CYC;
				end
			end
			OWN_HOLD: begin
				// wait out the sync delay of the released line
				if (st_r.hold == 4'h0) begin
					st_nxt.own = OWN_IDLE;
				end else begin
					st_nxt.hold = st_r.hold - 4'h1;
				end
			end
		endcase
		st_nxt.up_oe = (st_nxt.own == OWN_DN) && conn;
		// pin drivers
		for (int i = 0; i < GPIO_N; i++) begin
			st_nxt.pout[i] = st_r.dout[i];
			st_nxt.poe[i] = st_r.dir[i];
		end
		for (int i = 0; i < LO_N; i++) begin
			// flash level or plain output value
			lvl = st_r.alfen[i] ? st_r.led[i] : st_r.dout[i];
			// low-only styles drive just for a zero
			if (st_r.drv[2*i +: 2] == DRV_OD || st_r.drv[2*i +: 2] == DRV_OC) begin
				st_nxt.pout[i] = 1'b0;
				st_nxt.poe[i] = st_r.dir[i] & ~lvl;
			end else begin
				st_nxt.pout[i] = lvl;
			end
			// address inputs do not drive, except pins 0 and 2 while event or alert output is on
			if (st_r.iden[i]) begin
				st_nxt.poe[i] = 1'b0;
			end
		end
		// event pin high while an event is routed there
		if (st_r.func[FB_EVT]) begin
			st_nxt.pout[P_EVT] = |(st_r.stat & ~st_r.route);
			st_nxt.poe[P_EVT] = 1'b1;
		end
		// alert pin pulled low while an alert is pending
		if (st_r.func[FB_ALERT]) begin
			st_nxt.pout[P_ALERT] = 1'b0;
			st_nxt.poe[P_ALERT] = |(st_r.stat & st_r.route);
		end
		// select pins stay inputs
		if (st_r.func[FB_SELPIN]) begin
			st_nxt.poe[P_SEL0] = 1'b0;
			st_nxt.poe[P_SEL1] = 1'b0;
		end
		// segment pins float unless joined
		if (st_r.func[FB_SEG1]) begin
			st_nxt.poe[P_S1CLK] = 1'b0;
			st_nxt.poe[P_S1DAT] = 1'b0;
		end
		if (st_r.func[FB_SEG2]) begin
			st_nxt.poe[P_S2CLK] = 1'b0;
			st_nxt.poe[P_S2DAT] = 1'b0;
		end
		if (st_r.func[FB_SEG3]) begin
			st_nxt.poe[P_S3CLK] = 1'b0;
			st_nxt.poe[P_S3DAT] = 1'b0;
		end
		// joined segment follows primary clock and data
		if (conn) begin
			st_nxt.pout[cpin] = 1'b0;
			st_nxt.poe[cpin] = ~st_r.stb[SY_UPCLK];
			st_nxt.pout[dpin] = 1'b0;
			st_nxt.poe[dpin] = st_nxt.own == OWN_UP;
		end
		if (!pg) begin
			st_nxt.poe[GPIO_N-1:P_GATED] = '0;
		end
		// read data and answer, no wait state
		unique case (i_paddr)
			OFS_DIR: rd = 32'(st_r.dir);
			OFS_OUT: rd = 32'(st_r.dout);
			OFS_IN: rd = 32'(st_r.stb[GPIO_N-1:0]);
			OFS_FUNC: rd = 32'(st_r.func);
			OFS_ALT: rd = {16'h0000, st_r.iden, st_r.alfen};
			OFS_DRV: rd = 32'(st_r.drv);
			OFS_EVC: rd = {8'h00, st_r.route, st_r.irqen, st_r.erise};
			OFS_STAT: rd = 32'(st_r.stat);
			OFS_LED: rd = {8'h00, st_r.duty50, st_r.ldiv};
			OFS_STS: rd = {16'h0000, st_r.id, 3'h0, conn, st_r.own, sel};
			default: begin
				if (is_scr(i_paddr)) begin
					rd = 32'(st_r.scr[scr_idx(i_paddr)]);
				end
			end
		endcase
		st_nxt.pready = setup;
		st_nxt.pslverr = setup & ~is_map(i_paddr);
		st_nxt.prdata = (setup && !i_pwrite) ? rd : 32'h0000_0000;
		// synchronous reset to defaults
		if (!i_rst_n) begin
			st_nxt = '0;
			// sync stages start high like released pins
			st_nxt.stb = '1;
			st_nxt.s1 = '1;
			st_nxt.s2 = '1;
			st_nxt.s3 = '1;
			st_nxt.func = FUNC_RST;
			st_nxt.ldiv = LED_DIV_RST;
			st_nxt.own = OWN_IDLE;
		end
	end

	// state register
	always_ff @(posedge i_core_clk) begin
		st_r <= st_nxt;
	end

	// outputs straight from state
	assign o_pready = st_r.pready;
	assign o_pslverr = st_r.pslverr;
	assign o_prdata = st_r.prdata;
	assign o_upstream_bus_data = 1'b0;
	assign o_upstream_bus_data_oe = st_r.up_oe;
	assign o_gpio = st_r.pout;
	assign o_gpio_oe = st_r.poe;

endmodule // smbsg_top
`default_nettype wire

// [common/smbsg_pkg.sv]
// Notes on behaviour
// - primary joins at most one of three segments
// - select 00 none, 01 segment 1, 10 segment 2
// - select pin bit 1; 11 joins segment 3
// - pins 14/15 can carry segment 3
// - power-good low cuts every segment off
// - power-good low floats pins 8 to 19
// - pins 16-19 input, output or segment lines
// - pins 0-7 input, output, flash or address
// - pins 0-7 push-pull, open-drain or open-collector
// - pin 2 can pull the alert low
// - pin 0 can carry the event output
// - pins 8-15 input or output, inputs may raise interrupts
// - per pin rising or falling edge trigger
// - each event routes to event or alert
// - eight flash outputs, 10% or 50% duty
// - cascade address taken from address pins
// - ten scratchpad bytes, write and read back
// - flash timing from the 32 kHz input
// - primary bus keeps standard SMBus behaviour
`default_nettype none
package smbsg_pkg;
	// pin vector
	localparam int GPIO_N = 20;
	localparam int SYNC_N = 24;
	localparam int SY_UPCLK = 20;
	localparam int SY_UPDAT = 21;
	localparam int SY_HOST_POWER_GOOD = 22;
	localparam int SY_CLK32 = 23;
	// pin roles
	localparam int P_EVT = 0;
	localparam int P_ALERT = 2;
	localparam int P_SEL0 = 12;
	localparam int P_SEL1 = 13;
	localparam int P_S3DAT = 14;
	localparam int P_S3CLK = 15;
	localparam int P_S1CLK = 16;
	localparam int P_S1DAT = 17;
	localparam int P_S2CLK = 18;
	localparam int P_S2DAT = 19;
	localparam int P_GATED = 8;
	localparam int EV_LO = 8;
	localparam int LO_N = 8;
	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_OUT = 8'h04;
	localparam logic [7:0] OFS_IN = 8'h08;
	localparam logic [7:0] OFS_FUNC = 8'h0C;
	localparam logic [7:0] OFS_ALT = 8'h10;
	localparam logic [7:0] OFS_DRV = 8'h14;
	localparam logic [7:0] OFS_EVC = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	localparam logic [7:0] OFS_LED = 8'h20;
	localparam logic [7:0] OFS_STS = 8'h24;
	localparam logic [7:0] OFS_SCR = 8'h40;
	localparam int SCR_N = 10;
	// function register fields
	localparam int FB_EVT = 0;
	localparam int FB_ALERT = 1;
	localparam int FB_SEG1 = 2;
	localparam int FB_SEG2 = 3;
	localparam int FB_SEG3 = 4;
	localparam int FB_SELPIN = 5;
	localparam int FB_SELSW = 6;
	localparam logic [7:0] FUNC_RST = 8'h20;
	// drive styles
	localparam logic [1:0] DRV_PP = 2'h0;
	localparam logic [1:0] DRV_OD = 2'h1;
	localparam logic [1:0] DRV_OC = 2'h2;
	// segment select codes
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_SEG1 = 2'h1;
	localparam logic [1:0] SEL_SEG2 = 2'h2;
	localparam logic [1:0] SEL_SEG3 = 2'h3;
	// timing
	localparam logic [3:0] HOLD_CYC = 4'h4;
	localparam logic [15:0] LED_DIV_RST = 16'h4000;
	localparam int DUTY50_DIV = 2;
	localparam int DUTY10_DIV = 10;
	// data line ownership
	typedef enum logic [1:0] {
		OWN_IDLE = 2'b00,
		OWN_UP   = 2'b01,
		OWN_DN   = 2'b10,
		OWN_HOLD = 2'b11
	} smbsg_own_t;
endpackage
`default_nettype wire

// [tb/smbsg_top_monitor.sv]
`default_nettype none
module smbsg_top_monitor
	import smbsg_pkg::*;
(
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              o_pready,
	input  wire logic              o_pslverr,
	input  wire logic [31:0]       o_prdata,
	// primary bus, power and pins
	input  wire logic              o_upstream_bus_data,
	input  wire logic              o_upstream_bus_data_oe,
	input  wire logic              i_host_power_good,
	input  wire logic [GPIO_N-1:0] o_gpio_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// answer comes in the cycle after setup
	AST_PREADY_NEXT: assert property (i_psel && !i_penable |=> o_pready)
		else $error("pready missing after setup");
	// answer stands a single cycle
	AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	// answer only follows a setup cycle
	AST_PREADY_CAUSE: assert property ($rose(o_pready) |-> $past(i_psel) && !$past(i_penable))
		else $error("pready without setup");
	// error flag only with the answer
	AST_ERR_READY: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	// read data zero outside the answer and on errors
	AST_DATA_IDLE: assert property (!o_pready || o_pslverr |-> o_prdata == 32'h0)
		else $error("prdata not zero");
	// open drain primary data never drives high
	AST_UP_LOW_ONLY: assert property (o_upstream_bus_data_oe |-> !o_upstream_bus_data)
		else $error("primary data driven high");
	// pins released right after reset
	AST_RESET_IDLE: assert property ($rose(i_rst_n) |-> o_gpio_oe == '0 && !o_upstream_bus_data_oe)
		else $error("pins driven after reset");
	// power not good floats upper pins
	AST_HOST_POWER_GOOD_FLOAT: assert property (!i_host_power_good [*8] |-> o_gpio_oe[19:8] == 12'h000)
		else $error("upper pins driven while power not good");
	// power not good cuts the primary from segments
	AST_HOST_POWER_GOOD_CUT: assert property (!i_host_power_good [*8] |-> !o_upstream_bus_data_oe)
		else $error("primary pulled while power not good");
endmodule // smbsg_top_monitor
bind smbsg_top smbsg_top_monitor u_mon (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
	.o_upstream_bus_data(o_upstream_bus_data), .o_upstream_bus_data_oe(o_upstream_bus_data_oe),
	.i_host_power_good(i_host_power_good), .o_gpio_oe(o_gpio_oe));
`default_nettype wire

// [tb/smbsg_host_model.sv]
`default_nettype none
module smbsg_host_model (
	// primary bus lines seen by the device
	output logic      o_bus_clock,
	output logic      o_bus_data,
	// device pulling primary data low
	input  wire logic i_dev_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run = 1'b0;      // frame in progress
	logic pull_low = 1'b0; // host pulls data low
	initial begin
		o_bus_clock = 1'b1;
	end
	// clock runs only inside a frame, idles high on the pull-up
	always begin
		#80;
		o_bus_clock = run ? ~o_bus_clock : 1'b1;
	end
	// wired-and data line with pull-up
	assign o_bus_data = ~(pull_low | i_dev_data_oe);
endmodule // smbsg_host_model
`default_nettype wire

// [tb/test_smbus_selector_gpio_expander.sv]
`default_nettype none
module test_smbus_selector_gpio_expander
	import smbsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pg = 1, ck32 = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, up_clk, up_dat, up_do, up_oe, er;
	logic [19:0] pin_val = 20'hFC000, gi, go, goe; // segment pins pulled up
	int num_errors = 0, comparisons = 0, i;
	always #5 clk = ~clk;
	always #80 ck32 = ~ck32;
	// pin level from device drive and board
	assign gi = (goe & go) | (~goe & pin_val);
	smbsg_top u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_prdata(prdata), .i_upstream_bus_clock(up_clk),
		.i_upstream_bus_data(up_dat), .o_upstream_bus_data(up_do),
		.o_upstream_bus_data_oe(up_oe), .i_host_power_good(pg), .i_clk_32k(ck32),
		.i_gpio(gi), .o_gpio(go), .o_gpio_oe(goe));
	smbsg_host_model u_host (.o_bus_clock(up_clk), .o_bus_data(up_dat), .i_dev_data_oe(up_oe));
	// verdict
	task automatic test_done();
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("mismatch pready exp 1 got 0");
			test_done();
		end
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	task automatic wait_for(logic [19:0] m, logic [19:0] v);
		int n;
		n = 0;
		while ((goe & m) !== v && n < 40) begin @(posedge clk); n++; end
		chk("pin enables", {12'h0, v}, {12'h0, goe & m});
	endtask
	// wait until pin values match
	task automatic wait_out(logic [19:0] m, logic [19:0] v);
		int n;
		n = 0;
		while ((go & m) !== v && n < 40) begin @(posedge clk); n++; end
		chk("pin values", {12'h0, v}, {12'h0, go & m});
	endtask
	// cycles that a flashing pin stays high
	task automatic hi_len(string nm, int b, int exp);
		int n, h;
		n = 0;
		h = 0;
		while (go[b] !== 1'b0 && n < 400) begin @(posedge clk); n++; end
		while (go[b] !== 1'b1 && n < 400) begin @(posedge clk); n++; end
		while (go[b] === 1'b1 && n < 400) begin @(posedge clk); n++; h++; end
		chk(nm, 32'(exp), 32'(h));
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk("func reset", OFS_FUNC, {24'h0, FUNC_RST});
		rchk("dir reset", OFS_DIR, 32'h0);
		rchk("unmapped", 8'h30, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		for (i = 0; i < SCR_N; i++) apb(1'b1, OFS_SCR + 8'(4 * i), 32'hFFFFFF00 | i * 8'h11);
		for (i = 0; i < SCR_N; i++) rchk("scratch", OFS_SCR + 8'(4 * i), i * 8'h11);
		u_host.run <= 1'b1;
		// segment selection per code, host pulling data low
		for (i = 0; i < 4; i++) begin
			apb(1'b1, OFS_FUNC, 32'h1C | (i << 6));
			rchk("select", OFS_STS, {27'h0, i != 0, 2'h0, 2'(i)});
			u_host.pull_low <= 1'b1;
			repeat (12) @(posedge clk);
			chk("joined", {29'h0, i == 1, i == 2, i == 3}, {29'h0, goe[17], goe[19], goe[14]});
			u_host.pull_low <= 1'b0;
			repeat (20) @(posedge clk);
		end
		apb(1'b1, OFS_FUNC, 32'h1C | (1 << 6));
		pg <= 1'b0;
		u_host.pull_low <= 1'b1;
		repeat (12) @(posedge clk);
		chk("cut seg1", 32'h0, {31'h0, goe[17]});
		u_host.pull_low <= 1'b0;
		u_host.run <= 1'b0;
		pg <= 1'b1;
		apb(1'b1, OFS_FUNC, 32'h20);
		// drive styles on pin 1
		apb(1'b1, OFS_DIR, 32'h2);
		apb(1'b1, OFS_DRV, {28'h0, DRV_OD, 2'h0});
		apb(1'b1, OFS_OUT, 32'h2);
		wait_for(20'h2, 20'h0);
		apb(1'b1, OFS_OUT, 32'h0);
		wait_for(20'h2, 20'h2);
		chk("od low", 32'h0, {31'h0, go[1]});
		apb(1'b1, OFS_DRV, 32'h0);
		apb(1'b1, OFS_OUT, 32'h2);
		wait_for(20'h2, 20'h2);
		wait_out(20'h2, 20'h2);
		chk("pp high", 32'h1, {31'h0, go[1]});
		// flash on pin 1, ten ticks a period
		apb(1'b1, OFS_ALT, 32'h2);
		apb(1'b1, OFS_LED, 32'h0002000A);
		hi_len("flash 50", 1, 80);
		apb(1'b1, OFS_LED, 32'h0000000A);
		hi_len("flash 10", 1, 16);
		// cascade address taken from pin 3
		apb(1'b1, OFS_ALT, 32'h800);
		pin_val[3] <= 1'b1;
		repeat (8) @(posedge clk);
		rchk("address", OFS_STS, 32'h800);
		apb(1'b1, OFS_ALT, 32'h0);
		// power not good floats pins 8 to 19 only
		apb(1'b1, OFS_DIR, 32'hFFFFF);
		pg <= 1'b0;
		repeat (10) @(posedge clk);
		wait_for(20'hFFFFF, 20'h000FF);
		pg <= 1'b1;
		apb(1'b1, OFS_DIR, 32'h0);
		// pin 8 rising to event, pin 9 falling to alert
		apb(1'b1, OFS_FUNC, 32'h23);
		apb(1'b1, OFS_EVC, 32'h00020301);
		pin_val[9] <= 1'b1;
		repeat (10) @(posedge clk);
		rchk("no rise event", OFS_STAT, 32'h0);
		pin_val[8] <= 1'b1;
		wait_for(20'h1, 20'h1);
		wait_out(20'h1, 20'h1);
		chk("event high", 32'h1, {31'h0, go[0]});
		chk("no alert", 32'h0, {31'h0, goe[2]});
		pin_val[9] <= 1'b0;
		wait_for(20'h4, 20'h4);
		rchk("stat", OFS_STAT, 32'h3);
		apb(1'b1, OFS_STAT, 32'h3);
		rchk("stat clear", OFS_STAT, 32'h0);
		wait_for(20'h4, 20'h0);
		// reset in mid-run restores defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk("func re-reset", OFS_FUNC, {24'h0, FUNC_RST});
		rchk("evc re-reset", OFS_EVC, 32'h0);
		test_done();
	end
endmodule // test_smbus_selector_gpio_expander
`default_nettype wire
